/* embedded_ram_block.v */
// Configurable embedded RAM block with AHB-Lite control and preload window on small and medium sizes
`include "ram_consts.vh"
module embedded_ram_block #(
    parameter SIZE_SEL = 1,
    parameter ADDR_W = 16,
    parameter LANES = (SIZE_SEL == 0) ? 2 : (SIZE_SEL == 1) ? 4 : 16,
    parameter ROWS = (SIZE_SEL == 0) ? 32 : (SIZE_SEL == 1) ? 128 : 4096,
    parameter LG_R = (SIZE_SEL == 0) ? 5 : (SIZE_SEL == 1) ? 7 : 12
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ram_clr_n,
    input wire [ADDR_W-1:0] a_addr,
    input wire [LANES*9-1:0] a_din,
    input wire a_we,
    input wire a_re,
    input wire [LANES-1:0] a_ben,
    output reg [LANES*9-1:0] a_q,
    input wire [ADDR_W-1:0] b_addr,
    input wire [LANES*9-1:0] b_din,
    input wire b_we,
    input wire b_re,
    input wire [LANES-1:0] b_ben,
    output reg [LANES*9-1:0] b_q
);
    localparam DW = LANES * 9;
    localparam LG_L = (SIZE_SEL == 0) ? 1 : (SIZE_SEL == 1) ? 2 : 4;
    localparam [3:0] LG_DW = LG_L + 3;
    localparam LARGE = (SIZE_SEL == 2);
    localparam [2:0] KMIN = LARGE ? 3'h3 : 3'h0;
    localparam [2:0] KMAX = (SIZE_SEL == 0) ? 3'h4 : (SIZE_SEL == 1) ? 3'h5 : 3'h7;
    localparam [1:0] SIZE2 = SIZE_SEL;

    // Width code k: logical word holds 2**k data bits, parity lanes beside bytes
    function [2:0] clampk(input [2:0] k);
        begin
            clampk = (k < KMIN) ? KMIN : (k > KMAX) ? KMAX : k;
        end
    endfunction

    // Lay a logical word into its slot of a physical row
    function [DW-1:0] merge(input [DW-1:0] old, input [DW-1:0] din, input [LANES-1:0] ben,
                            input [ADDR_W-1:0] slot, input [2:0] k, input par, input use_ben);
        integer p, lane, bp, ol, di;
        begin
            merge = old;
            for (p = 0; p < DW; p = p + 1) begin
                lane = p / 9;
                bp = p % 9;
                if (k >= 3) begin
                    ol = lane % (1 << (k - 3));
                    if ((lane >> (k - 3)) == slot && (bp < 8 || par) && (ben[ol] || !use_ben)) begin
                        merge[p] = din[ol * 9 + bp];
                    end
                end else if (bp < 8) begin
                    di = lane * 8 + bp;
                    if ((di >> k) == slot) begin
                        merge[p] = din[di % (1 << k)];
                    end
                end
            end
        end
    endfunction

    // Pull one logical word out of a physical row
    function [DW-1:0] extract(input [DW-1:0] word, input [ADDR_W-1:0] slot, input [2:0] k, input par);
        integer o, lane, bp, di;
        begin
            extract = {DW{1'b0}};
            for (o = 0; o < DW; o = o + 1) begin
                lane = o / 9;
                bp = o % 9;
                if (k >= 3) begin
                    if (lane < (1 << (k - 3)) && (bp < 8 || par)) begin
                        extract[o] = word[(slot * (1 << (k - 3)) + lane) * 9 + bp];
                    end
                end else if (lane == 0 && bp < (1 << k)) begin
                    di = slot * (1 << k) + bp;
                    extract[o] = word[(di / 8) * 9 + di % 8];
                end
            end
        end
    endfunction

    reg [DW-1:0] mem [0:ROWS-1];
    reg [8:0] ctrl_q;
    reg coll_q;
    reg dwr_q;
    reg drd_q;
    reg [19:0] daddr_q;
    reg [ADDR_W-1:0] a_addr_q;
    reg [DW-1:0] a_din_q;
    reg a_we_q;
    reg a_re_q;
    reg [LANES-1:0] a_ben_q;
    reg [ADDR_W-1:0] b_addr_q;
    reg [DW-1:0] b_din_q;
    reg b_we_q;
    reg b_re_q;
    reg [LANES-1:0] b_ben_q;
    reg [DW-1:0] pa_q;
    reg [DW-1:0] pb_q;

    // large block clear spares the input registers
    wire in_rst_n = hresetn & (ram_clr_n | LARGE);
    wire out_rst_n = hresetn & ram_clr_n;

    wire [2:0] kw = clampk(ctrl_q[`CTRL_WID_LSB+2:`CTRL_WID_LSB]);
    wire par = ctrl_q[`CTRL_PAR_BIT];
    wire en = ctrl_q[`CTRL_EN_BIT];
    wire [1:0] mode_raw = ctrl_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
    // no true dual-port on the small block
    // large ROM behaves as dual-port so it can be loaded by writes
    wire [1:0] mode = (mode_raw == `MODE_TDP && SIZE_SEL == 0) ? `MODE_SDP :
                      (mode_raw == `MODE_ROM && LARGE) ? `MODE_TDP : mode_raw;
    wire [3:0] lgs = LG_DW - {1'b0, kw};
    wire [ADDR_W-1:0] smask = ~({ADDR_W{1'b1}} << lgs);
    wire [ADDR_W-1:0] row_a = a_addr_q >> lgs;
    wire [ADDR_W-1:0] row_b = b_addr_q >> lgs;
    wire [LG_R-1:0] ia = row_a[LG_R-1:0];
    wire [LG_R-1:0] ib = row_b[LG_R-1:0];
    wire [ADDR_W-1:0] slot_a = a_addr_q & smask;
    wire [ADDR_W-1:0] slot_b = b_addr_q & smask;
    wire use_ben = (SIZE_SEL != 0);

    // single-port: write wins, no separate read in a write cycle
    // true dual-port: any pairing on both ports
    wire wa = en && a_we_q && mode != `MODE_ROM;
    wire wb = en && b_we_q && mode == `MODE_TDP;
    wire ra = en && (a_re_q || wa) && (mode == `MODE_SP || mode == `MODE_TDP || mode == `MODE_ROM);
    wire rb = en && b_re_q && mode != `MODE_SP;
    wire [DW-1:0] old_a = mem[ia];
    wire [DW-1:0] old_b = mem[ib];
    wire [DW-1:0] new_a = merge(old_a, a_din_q, a_ben_q, slot_a, kw, par, use_ben);
    wire [DW-1:0] base_b = (wa && ia == ib) ? new_a : old_b;
    wire [DW-1:0] new_b = merge(base_b, b_din_q, b_ben_q, slot_b, kw, par, use_ben);
    wire coll = wa && rb && ia == ib && mode == `MODE_SDP;
    // single-port write reads back the new word
    wire [DW-1:0] rda = extract((mode == `MODE_SP && wa) ? new_a : old_a, slot_a, kw, par);
    // same-address read: old data, or all ones standing for undefined
    wire [DW-1:0] rdb = (coll && !ctrl_q[`CTRL_OLD_BIT]) ? {DW{1'b1}} : extract(old_b, slot_b, kw, par);

    // AHB preload window: one 9-bit lane per word
    wire [15:0] widx = daddr_q[17:2];
    wire [15:0] wrow = widx >> LG_L;
    wire [LG_R-1:0] wi = wrow[LG_R-1:0];
    localparam [31:0] LANE_MASK = LANES - 1;
    wire [15:0] wlane = widx & LANE_MASK[15:0];
    wire win = daddr_q[`WIN_BIT] && wrow < ROWS;
    // preload only on small/medium while the ports are off
    wire pl_we = dwr_q && win && !LARGE && !en;
    reg [DW-1:0] pl_word;
    reg [8:0] lane_rd;
    integer p;

    always @* begin
        pl_word = mem[wi];
        lane_rd = 9'h000;
        for (p = 0; p < DW; p = p + 1) begin
            if (p / 9 == wlane) begin
                pl_word[p] = hwdata[p % 9];
                lane_rd[p % 9] = mem[wi][p];
            end
        end
    end

    // Array write, one process so ports and preload share one driver
    always @(posedge hclk) begin
        if (wa) begin
            mem[ia] <= new_a;
        end
        if (wb) begin
            mem[ib] <= new_b;
        end
        if (pl_we) begin
            mem[wi] <= pl_word;
        end
    end

    // clear takes these at once on small and medium blocks, as it does the output registers
    always @(posedge hclk or negedge in_rst_n) begin
        if (!in_rst_n) begin
            a_addr_q <= {ADDR_W{1'b0}};
            a_din_q <= {DW{1'b0}};
            a_we_q <= 1'b0;
            a_re_q <= 1'b0;
            a_ben_q <= {LANES{1'b0}};
            b_addr_q <= {ADDR_W{1'b0}};
            b_din_q <= {DW{1'b0}};
            b_we_q <= 1'b0;
            b_re_q <= 1'b0;
            b_ben_q <= {LANES{1'b0}};
        end else begin
            a_addr_q <= a_addr;
            a_din_q <= a_din;
            a_we_q <= a_we;
            a_re_q <= a_re;
            a_ben_q <= a_ben;
            b_addr_q <= b_addr;
            b_din_q <= b_din;
            b_we_q <= b_we;
            b_re_q <= b_re;
            b_ben_q <= b_ben;
        end
    end

    // output registers clear without a clock edge
    always @(posedge hclk or negedge out_rst_n) begin
        if (!out_rst_n) begin
            pa_q <= {DW{1'b0}};
            pb_q <= {DW{1'b0}};
            a_q <= {DW{1'b0}};
            b_q <= {DW{1'b0}};
        end else begin
            if (ra) begin
                pa_q <= rda;
            end
            if (rb) begin
                pb_q <= rdb;
            end
            if (ctrl_q[`CTRL_OREG_BIT]) begin
                a_q <= pa_q;
                b_q <= pb_q;
            end else begin
                if (ra) begin
                    a_q <= rda;
                end
                if (rb) begin
                    b_q <= rdb;
                end
            end
        end
    end

    // AHB-Lite slave; reads take one wait state so a prior write is visible
    wire take = hsel && hready && htrans[1];
    wire [31:0] stat = {23'h000000, coll_q, 1'b0, kw, !LARGE, SIZE_SEL != 0, SIZE2};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr_q <= 1'b0;
            drd_q <= 1'b0;
            daddr_q <= 20'h00000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            ctrl_q <= `CTRL_RST;
            coll_q <= 1'b0;
        end else begin
            dwr_q <= take && hwrite;
            drd_q <= take && !hwrite;
            if (take) begin
                daddr_q <= haddr[19:0];
            end
            hreadyout <= !(take && !hwrite);
            if (drd_q) begin
                if (daddr_q[`WIN_BIT]) begin
                    hrdata <= win ? {23'h000000, lane_rd} : 32'h00000000;
                end else if (daddr_q[17:2] == `CTRL_OFS >> 2) begin
                    hrdata <= {23'h000000, ctrl_q};
                end else if (daddr_q[17:2] == `STAT_OFS >> 2) begin
                    hrdata <= stat;
                end else begin
                    hrdata <= 32'h00000000;
                end
            end
            if (dwr_q && !daddr_q[`WIN_BIT] && daddr_q[17:2] == `CTRL_OFS >> 2) begin
                ctrl_q <= hwdata[8:0];
            end
            // Collision flag: hardware set beats software clear
            if (coll) begin
                coll_q <= 1'b1;
            end else if (dwr_q && !daddr_q[`WIN_BIT] && daddr_q[17:2] == `STAT_OFS >> 2 &&
                         hwdata[`STAT_COLL_BIT]) begin
                coll_q <= 1'b0;
            end
        end
    end
endmodule

/* fabric_user.sv */
// User-logic model that drives both RAM ports
module fabric_user #(parameter ADDR_W = 16, parameter LANES = 4) (
    input wire hclk,
    output logic [ADDR_W-1:0] a_addr,
    output logic [LANES*9-1:0] a_din,
    output logic a_we,
    output logic a_re,
    output logic [ADDR_W-1:0] b_addr,
    output logic [LANES*9-1:0] b_din,
    output logic b_we,
    output logic b_re,
    output logic [LANES-1:0] ben
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {a_addr, a_din, a_we, a_re, b_addr, b_din, b_we, b_re} = '0;
        ben = '1;
    end
    task op(input logic aw, ar, input logic [ADDR_W-1:0] aa, input logic [LANES*9-1:0] ad,
            input logic bw, br, input logic [ADDR_W-1:0] ba, input logic [LANES*9-1:0] bd,
            input logic [LANES-1:0] be);
        @(posedge hclk);
        {a_we, a_re, a_addr, a_din} <= {aw, ar, aa, ad};
        {b_we, b_re, b_addr, b_din} <= {bw, br, ba, bd};
        ben <= be;
        @(posedge hclk);
        {a_we, a_re, b_we, b_re} <= 4'h0;
        // Released lines must not look valid
        {a_addr, a_din, b_addr, b_din} <= ~{aa, ad, ba, bd};
    endtask
endmodule

/* ram_consts.vh */
// Register offsets, field positions and reset values of the embedded RAM block
`ifndef RAM_CONSTS_VH
`define RAM_CONSTS_VH
`define CTRL_OFS 20'h00000
`define STAT_OFS 20'h00004
`define WIN_BIT 18
`define CTRL_MODE_LSB 0
`define CTRL_WID_LSB 2
`define CTRL_PAR_BIT 5
`define CTRL_OREG_BIT 6
`define CTRL_OLD_BIT 7
`define CTRL_EN_BIT 8
`define CTRL_RST 9'h100
`define STAT_COLL_BIT 8
`define MODE_SP 2'h0
`define MODE_SDP 2'h1
`define MODE_TDP 2'h2
`define MODE_ROM 2'h3
`endif

/* ram_port_assertions.sv */
// Port-level assertions for the embedded RAM block
module ram_port_assertions #(parameter LANES = 4) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire ram_clr_n,
    input wire a_we,
    input wire a_re,
    input wire b_we,
    input wire b_re,
    input wire [LANES*9-1:0] a_q,
    input wire [LANES*9-1:0] b_q
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans[1];
    wire a_op = a_we || a_re;
    wire b_op = b_we || b_re;
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    wait_one_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("hrdata moved outside a read");
    clr_out_a: assert property (!ram_clr_n |-> a_q == '0 && b_q == '0)
        else $error("clear did not reach outputs");
    a_hold_a: assert property ((!a_op && ram_clr_n)[*4] |-> $stable(a_q))
        else $error("a_q moved without an operation");
    b_hold_a: assert property ((!b_op && ram_clr_n)[*4] |-> $stable(b_q))
        else $error("b_q moved without an operation");
    a_early_a: assert property ((!a_op && ram_clr_n)[*3] ##1 (a_op && ram_clr_n) |-> $stable(a_q))
        else $error("a_q answered before inputs were registered");
endmodule

bind embedded_ram_block ram_port_assertions #(.LANES(LANES)) chk_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ram_clr_n(ram_clr_n), .a_we(a_we), .a_re(a_re), .b_we(b_we), .b_re(b_re), .a_q(a_q),
    .b_q(b_q));

/* testbench.sv */
// Self-checking bench for the medium embedded RAM block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [35:0] D1 = 36'h9_8765_4321, D2 = 36'hA_5A5A_5A5A, D3 = 36'h3_3333_3333;
    localparam logic [35:0] D4 = 36'h1_2345_6789, D5 = 36'hE_DCBA_9876, M = 36'h0_07FC_01FF;
    localparam logic [35:0] W = {9'h0CC, 9'h133, 9'h05A, 9'h1A5};
    logic hclk, hresetn, hsel, hwrite, ram_clr_n;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, a_we, a_re, b_we, b_re;
    wire [15:0] a_addr, b_addr;
    wire [35:0] a_din, b_din, a_q, b_q;
    wire [3:0] ben;
    int checks = 0;
    int mismatches = 0;
    embedded_ram_block #(.SIZE_SEL(1)) embedded_ram_block_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ram_clr_n(ram_clr_n), .a_addr(a_addr),
        .a_din(a_din), .a_we(a_we), .a_re(a_re), .a_ben(ben), .a_q(a_q), .b_addr(b_addr), .b_din(b_din),
        .b_we(b_we), .b_re(b_re), .b_ben(ben), .b_q(b_q));
    fabric_user fabric_user_inst (.hclk(hclk), .a_addr(a_addr), .a_din(a_din), .a_we(a_we), .a_re(a_re),
        .b_addr(b_addr), .b_din(b_din), .b_we(b_we), .b_re(b_re), .ben(ben));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cmp(input string name, input logic [35:0] exp, input logic [35:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // No wait count assumed; the watchdog ends a hang
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(name, {4'h0, exp}, {4'h0, rd});
    endtask
    task tick(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
    initial begin
        {hsel, htrans, hwrite, haddr, hwdata} = 68'h0;
        ram_clr_n = 1'b1;
        hresetn = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        cmp("a_q", 36'h0, a_q);
        rdc("ctrl", 32'h0, 32'h0000_0100);
        rdc("status", 32'h4, 32'h0000_000D);
        rdc("unmapped", 32'h10, 32'h0);
        $display("test reset finished");
        bus(1'b1, 32'h0, 32'h0000_0134);
        rdc("status", 32'h4, 32'h0000_005D);
        fabric_user_inst.op(1, 0, 16'h3, D1, 0, 0, 0, 0, 4'hF);
        tick(1);
        cmp("a_q bypass", D1, a_q);
        bus(1'b1, 32'h0, 32'h0000_0174);
        fabric_user_inst.op(1, 0, 16'h4, D2, 0, 0, 0, 0, 4'hF);
        tick(1);
        cmp("a_q early", D1, a_q);
        tick(1);
        cmp("a_q registered", D2, a_q);
        fabric_user_inst.op(1, 0, 16'h4, D3, 0, 0, 0, 0, 4'h5);
        tick(2);
        cmp("a_q masked", (D3 & M) | (D2 & ~M), a_q);
        fabric_user_inst.op(0, 1, 16'h3, 0, 0, 0, 0, 0, 4'hF);
        tick(2);
        cmp("a_q parity", D1, a_q);
        $display("test single_port finished");
        bus(1'b1, 32'h0, 32'h0000_0135);
        fabric_user_inst.op(1, 0, 16'h4, D4, 0, 1, 16'h4, 0, 4'hF);
        tick(1);
        cmp("b_q undefined", 36'hF_FFFF_FFFF, b_q);
        rdc("status", 32'h4, 32'h0000_015D);
        bus(1'b1, 32'h4, 32'h0000_0100);
        rdc("status", 32'h4, 32'h0000_005D);
        bus(1'b1, 32'h0, 32'h0000_01B5);
        fabric_user_inst.op(1, 0, 16'h4, D5, 0, 1, 16'h4, 0, 4'hF);
        tick(1);
        cmp("b_q old", D4, b_q);
        $display("test simple_dual finished");
        bus(1'b1, 32'h0, 32'h0000_0136);
        fabric_user_inst.op(1, 0, 16'h5, D1, 1, 0, 16'h6, D2, 4'hF);
        fabric_user_inst.op(0, 1, 16'h6, 0, 0, 1, 16'h5, 0, 4'hF);
        tick(1);
        cmp("a_q", D2, a_q);
        cmp("b_q", D1, b_q);
        @(posedge hclk);
        ram_clr_n <= 1'b0;
        #1;
        cmp("a_q cleared", 36'h0, a_q);
        cmp("b_q cleared", 36'h0, b_q);
        @(posedge hclk);
        ram_clr_n <= 1'b1;
        fabric_user_inst.op(0, 1, 16'h5, 0, 0, 0, 0, 0, 4'hF);
        tick(1);
        cmp("a_q kept", D1, a_q);
        $display("test dual_clear finished");
        // Ports off so the window may load row 7, one lane per word
        bus(1'b1, 32'h0, 32'h0000_0034);
        bus(1'b1, 32'h0004_0070, 32'h0000_01A5);
        bus(1'b1, 32'h0004_0074, 32'h0000_005A);
        bus(1'b1, 32'h0004_0078, 32'h0000_0133);
        bus(1'b1, 32'h0004_007C, 32'h0000_00CC);
        rdc("window", 32'h0004_0074, 32'h0000_005A);
        bus(1'b1, 32'h0, 32'h0000_0137);
        bus(1'b1, 32'h0004_0070, 32'h0000_00FF);
        rdc("window locked", 32'h0004_0070, 32'h0000_01A5);
        fabric_user_inst.op(1, 1, 16'h7, D5, 0, 1, 16'h7, 0, 4'hF);
        tick(1);
        cmp("a_q rom", W, a_q);
        cmp("b_q rom", W, b_q);
        fabric_user_inst.op(0, 1, 16'h7, 0, 0, 0, 0, 0, 4'hF);
        tick(1);
        cmp("a_q rom kept", W, a_q);
        $display("test preload_rom finished");
        test_done();
    end
endmodule
